// file: core/nand_target_control_init.sv
// host controller: power-on init, write protect control, command issue
// assumes one target, ready/busy pulled up outside, inputs synchronous to ref_clk
`timescale 1ns/1ps
`default_nettype none
module nand_target_control_init
    import nand_host_pkg::*;
#(
    parameter int POWER_WAIT = nand_host_pkg::POWER_WAIT_CYC,
    parameter int RESET_BUSY = nand_host_pkg::RESET_BUSY_CYC
) (
    // clocking
    input  wire logic       ref_clk,
    input  wire logic       rst_n,
    input  wire logic       clkEn,
    // user request
    input  wire logic       reqValid,
    input  wire logic [7:0] reqOpcode,
    input  wire logic [23:0] reqAddr,
    input  wire logic [31:0] reqData,
    input  wire logic       reqProtect_n,
    input  wire logic       monitorRb,
    output logic            reqReady,
    output logic            rspValid,
    output logic [7:0]      rspData,
    output logic            rspRefused,
    output logic            initDone,
    // nand pins
    output logic            chipEnable_n,
    output logic            cmdLatch,
    output logic            addrLatch,
    output logic            writeStrobe_n,
    output logic            read_strobe_n,
    output logic            writeProtect_n,
    output logic [7:0]      ioOut,
    output logic            ioOe,
    input  wire logic [7:0] ioIn,
    input  wire logic       readyBusy_n
);
    import nand_host_pkg::*;
    nand_cycle_if cycBus ();
    seq_state_t   state_ff;
    seq_state_t   nxt_state;
    logic [CNT_W-1:0] cnt_ff;
    logic [7:0]   op_ff;
    logic [23:0]  addr_ff;
    logic [31:0]  data_ff;
    logic [2:0]   idx_ff;
    logic [2:0]   addrCnt;
    logic         hasDin;
    logic         hasDout;
    logic         busyOk;
    logic         targetReady;
    logic         powerDone;
    logic         resetDone;
    logic         wpDone;
    logic         wpChange;
    logic         cycDone;
    logic         opStatus;
    logic         stateMove;
    logic         takeReq;

    // opcode decode: address count, data direction, busy acceptance
    assign addrCnt = (op_ff == OP_STATUS_ENH) ? ADDR_CYC_ENH :
                     (op_ff == OP_STATUS || op_ff == OP_RESET) ? 3'h0 :
                     ADDR_CYC_ONE;
    assign opStatus = (op_ff == OP_STATUS) || (op_ff == OP_STATUS_ENH);
    assign hasDin  = (op_ff == OP_SET_FEAT);
    assign hasDout = !hasDin && (op_ff != OP_RESET);
    assign busyOk  = (reqOpcode == OP_STATUS) || (reqOpcode == OP_STATUS_ENH) ||
                     (reqOpcode == OP_RESET);
    // wired-or line: low means some die is busy
    assign targetReady = readyBusy_n;
    assign powerDone   = (cnt_ff >= CNT_W'(POWER_WAIT));
    assign resetDone   = (cnt_ff >= CNT_W'(RESET_BUSY));
    assign wpDone      = (cnt_ff >= CNT_W'(PROTECT_WAIT_CYC));
    assign wpChange    = (reqProtect_n != writeProtect_n);
    assign cycDone     = cycBus.done;
    assign stateMove   = (state_ff != nxt_state);
    assign takeReq     = (state_ff == ST_IDLE) && (nxt_state == ST_CMD);

    // cycle request towards the strobe engine
    assign cycBus.req    = (state_ff == ST_RST_CMD) || (state_ff == ST_CMD) ||
                           (state_ff == ST_ADDR) || (state_ff == ST_DIN) ||
                           (state_ff == ST_DOUT);
    assign cycBus.kind   = (state_ff == ST_ADDR) ? CYC_ADDR :
                           (state_ff == ST_DIN)  ? CYC_DIN  :
                           (state_ff == ST_DOUT) ? CYC_DOUT : CYC_CMD;
    assign cycBus.wrData = (state_ff == ST_RST_CMD) ? OP_RESET :
                           (state_ff == ST_CMD)  ? op_ff :
                           (state_ff == ST_ADDR) ? addr_ff[8*idx_ff[1:0] +: 8] :
                           data_ff[8*idx_ff[1:0] +: 8];

    // next state
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            // no monitoring: fixed wait; monitoring: wait for line high
            ST_POWER:    if (powerDone || monitorRb) nxt_state = ST_WAIT_RDY;
            ST_WAIT_RDY: if (targetReady) nxt_state = ST_RST_CMD;
            ST_RST_CMD:  if (cycDone) nxt_state = ST_RST_BUSY;
            ST_RST_BUSY: if (resetDone && targetReady) nxt_state = ST_IDLE;
            ST_IDLE: begin
                // protect level moves only while ready and between sequences
                if (targetReady && wpChange) nxt_state = ST_WP_WAIT;
                else if (reqValid && (targetReady || busyOk)) nxt_state = ST_CMD;
            end
            ST_WP_WAIT:  if (wpDone) nxt_state = ST_IDLE;
            ST_CMD: begin
                if (cycDone) begin
                    if (op_ff == OP_RESET) nxt_state = ST_RST_BUSY;
                    else if (addrCnt != 3'h0) nxt_state = ST_ADDR;
                    else nxt_state = ST_DOUT;
                end
            end
            // status skips the ready check, a busy die must still answer it
            ST_ADDR: if (cycDone && idx_ff == addrCnt - 3'h1) begin
                if (hasDin) nxt_state = ST_DIN;
                else if (opStatus) nxt_state = ST_DOUT;
                else nxt_state = ST_BUSY_CHK;
            end
            ST_DIN:      if (cycDone && idx_ff == DATA_CYC_FEAT - 3'h1) nxt_state = ST_BUSY_CHK;
            ST_BUSY_CHK: if (targetReady) nxt_state = hasDout ? ST_DOUT : ST_IDLE;
            ST_DOUT:     if (cycDone) nxt_state = ST_IDLE;
            default:     nxt_state = ST_POWER;
        endcase
    end

    // state register
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_ff <= ST_POWER;
        end else if (clkEn) begin
            state_ff <= nxt_state;
        end
    end

    // byte index inside the address or data phase
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            idx_ff <= 3'h0;
        end else if (clkEn) begin
            if (stateMove) idx_ff <= 3'h0;
            else if (cycDone) idx_ff <= idx_ff + 3'h1;
        end
    end

    // wait counter restarts per state; saturates so a long idle cannot wrap
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_ff <= '0;
        end else if (clkEn) begin
            if (stateMove) cnt_ff <= '0;
            else if (cnt_ff != '1) cnt_ff <= cnt_ff + CNT_W'(1);
        end
    end

    // request fields held for the whole sequence
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            op_ff   <= 8'h00_00;
            addr_ff <= 24'h00_0000;
            data_ff <= 32'h0000_0000;
        end else if (clkEn && takeReq) begin
            op_ff   <= reqOpcode;
            addr_ff <= reqAddr;
            data_ff <= reqData;
        end
    end

    // protect pin: low from power-on, moved only on entry to the protect wait
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            writeProtect_n <= 1'b0;
        end else if (clkEn && state_ff == ST_IDLE && nxt_state == ST_WP_WAIT) begin
            writeProtect_n <= reqProtect_n;
        end
    end

    // pins and user answers, all registered
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            chipEnable_n   <= 1'b1;
            reqReady       <= 1'b0;
            rspValid       <= 1'b0;
            rspData        <= 8'h00_00;
            rspRefused     <= 1'b0;
            initDone       <= 1'b0;
        end else if (clkEn) begin
            rspValid   <= 1'b0;
            rspRefused <= 1'b0;
            chipEnable_n <= (nxt_state == ST_POWER) || (nxt_state == ST_WAIT_RDY) ||
                            (nxt_state == ST_IDLE) || (nxt_state == ST_WP_WAIT);
            reqReady <= (nxt_state == ST_IDLE) && (state_ff == ST_IDLE);
            if (state_ff == ST_RST_BUSY && nxt_state == ST_IDLE) initDone <= 1'b1;
            // busy target drops requests that need a ready die
            if (state_ff == ST_IDLE && reqValid && !targetReady && !busyOk && !wpChange)
                rspRefused <= 1'b1;
            if (state_ff == ST_DOUT && cycDone) begin
                rspValid <= 1'b1;
                rspData  <= cycBus.rdData;
            end else if (state_ff == ST_BUSY_CHK && targetReady && !hasDout) begin
                rspValid <= 1'b1;
            end
        end
    end

    // strobe engine owns the latch and strobe pins
    nand_strobe_engine engine (
        .ref_clk       (ref_clk),
        .rst_n         (rst_n),
        .clkEn         (clkEn),
        .cyc           (cycBus.eng),
        .cmdLatch      (cmdLatch),
        .addrLatch     (addrLatch),
        .writeStrobe_n (writeStrobe_n),
        .read_strobe_n (read_strobe_n),
        .ioOut         (ioOut),
        .ioOe          (ioOe),
        .ioIn          (ioIn)
    );
endmodule
`default_nettype wire

// file: core/nand_host_pkg.sv
// constants for the host-side nand target controller
// assumes one target on an asynchronous strobe bus, one 125 MHz clock
// Contract
// - host holds write protect low from power-on until supply is stable.
// - host changes write protect only while ready and between command sequences.
// - host waits the protect-to-command interval after any write-protect change.
// - ready/busy valid 50us after ramp start; no reset before valid high.
// - non-monitoring host waits 100us after supply minimum; monitoring waits high.
// - host sends reset FFh to every target before any other command.
// - command latched on rising write strobe, cmd latch high, addr latch low.
// - address latched on rising write strobe, addr latch high, cmd latch low.
package nand_host_pkg;
    // opcodes
    localparam logic [7:0] OP_RESET      = 8'h00_FF;
    localparam logic [7:0] OP_READ_ID    = 8'h00_90;
    localparam logic [7:0] OP_PARAM_PAGE = 8'h00_EC;
    localparam logic [7:0] OP_UNIQUE_ID  = 8'h00_ED;
    localparam logic [7:0] OP_GET_FEAT   = 8'h00_EE;
    localparam logic [7:0] OP_SET_FEAT   = 8'h00_EF;
    localparam logic [7:0] OP_STATUS     = 8'h00_70;
    localparam logic [7:0] OP_STATUS_ENH = 8'h00_78;
    // address and data cycle counts
    localparam logic [2:0] ADDR_CYC_ONE  = 3'h1;
    localparam logic [2:0] ADDR_CYC_ENH  = 3'h3;
    localparam logic [2:0] DATA_CYC_FEAT = 3'h4;
    // timing, in ns and in clock cycles at 125 MHz
    localparam int CLK_PERIOD_NS      = 8;
    localparam int POWER_WAIT_NS      = 100_000;
    localparam int RESET_BUSY_NS      = 1_000_000;
    localparam int PROTECT_WAIT_NS    = 100;
    localparam int POWER_WAIT_CYC     = (POWER_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RESET_BUSY_CYC     = (RESET_BUSY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int PROTECT_WAIT_CYC   = (PROTECT_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // strobe phase length: each strobe half lasts this many cycles (>= 20 ns)
    localparam logic [1:0] STROBE_CYC = 2'h3;
    localparam int CNT_W              = 20;
    // bus cycle kinds passed to the strobe engine
    typedef enum logic [1:0] {
        CYC_CMD  = 2'b00,
        CYC_ADDR = 2'b01,
        CYC_DIN  = 2'b10,
        CYC_DOUT = 2'b11
    } cyc_kind_t;
    // sequencer states
    typedef enum logic [3:0] {
        ST_POWER    = 4'b0000,
        ST_WAIT_RDY = 4'b0001,
        ST_RST_CMD  = 4'b0010,
        ST_RST_BUSY = 4'b0011,
        ST_IDLE     = 4'b0100,
        ST_WP_WAIT  = 4'b0101,
        ST_CMD      = 4'b0110,
        ST_ADDR     = 4'b0111,
        ST_DIN      = 4'b1000,
        ST_DOUT     = 4'b1001,
        ST_BUSY_CHK = 4'b1010
    } seq_state_t;
endpackage

// file: core/nand_cycle_if.sv
// handshake between the sequencer and the strobe engine
// assumes both ends share ref_clk
`timescale 1ns/1ps
`default_nettype none
interface nand_cycle_if;
    import nand_host_pkg::*;
    logic      req;
    cyc_kind_t kind;
    logic [7:0] wrData;
    logic       done;
    logic [7:0] rdData;
    modport seq (output req, output kind, output wrData, input done, input rdData);
    modport eng (input req, input kind, input wrData, output done, output rdData);
endinterface
`default_nettype wire

// file: core/nand_strobe_engine.sv
// one asynchronous bus cycle: command, address, data in or data out
// assumes chip enable is held low by the sequencer during a sequence
`timescale 1ns/1ps
`default_nettype none
module nand_strobe_engine
    import nand_host_pkg::*;
(
    // clocking
    input  wire logic       ref_clk,
    input  wire logic       rst_n,
    input  wire logic       clkEn,
    // sequencer side
    nand_cycle_if.eng       cyc,
    // pins
    output logic            cmdLatch,
    output logic            addrLatch,
    output logic            writeStrobe_n,
    output logic            read_strobe_n,
    output logic [7:0]      ioOut,
    output logic            ioOe,
    input  wire logic [7:0] ioIn
);
    import nand_host_pkg::*;
    logic [1:0] phase_ff;
    logic [1:0] tick_ff;
    logic       isWrite;
    logic       tickEnd;
    assign isWrite = (cyc.kind != CYC_DOUT);
    assign tickEnd = (tick_ff == STROBE_CYC - 2'h1);

    // phase 0 idle, 1 strobe low, 2 strobe high hold; data taken on the rising edge
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            phase_ff      <= 2'h0;
            tick_ff       <= 2'h0;
            cmdLatch      <= 1'b0;
            addrLatch     <= 1'b0;
            writeStrobe_n <= 1'b1;
            read_strobe_n <= 1'b1;
            ioOut         <= 8'h00_00;
            ioOe          <= 1'b0;
            cyc.done      <= 1'b0;
            cyc.rdData    <= 8'h00_00;
        end else if (clkEn) begin
            cyc.done <= 1'b0;
            tick_ff  <= tickEnd ? 2'h0 : tick_ff + 2'h1;
            case (phase_ff)
                2'h0: begin
                    tick_ff <= 2'h0;
                    if (cyc.req && !cyc.done) begin
                        phase_ff  <= 2'h1;
                        cmdLatch  <= (cyc.kind == CYC_CMD);
                        addrLatch <= (cyc.kind == CYC_ADDR);
                        ioOut     <= cyc.wrData;
                        ioOe      <= isWrite;
                        writeStrobe_n <= !isWrite;
                        read_strobe_n <= isWrite;
                    end
                end
                2'h1: if (tickEnd) begin
                    phase_ff      <= 2'h2;
                    writeStrobe_n <= 1'b1; // rising edge latches cmd/addr/data
                    read_strobe_n <= 1'b1;
                    if (!isWrite) cyc.rdData <= ioIn;
                end
                2'h2: if (tickEnd) begin
                    // latches drop only after the hold phase
                    phase_ff  <= 2'h0;
                    cmdLatch  <= 1'b0;
                    addrLatch <= 1'b0;
                    ioOe      <= 1'b0;
                    cyc.done  <= 1'b1;
                end
                default: phase_ff <= 2'h0;
            endcase
        end
    end
endmodule
`default_nettype wire

// file: tb/nand_target_control_init_checker.sv
// pin and handshake checks for the host nand controller
// assumes binding onto nand_target_control_init, one clock domain
`timescale 1ns/1ps
`default_nettype none
module nand_target_control_init_checker
    import nand_host_pkg::*;
#(
    parameter int POWER_WAIT = 20,
    parameter int RESET_BUSY = 40
) (
    // clocking
    input wire logic       ref_clk,
    input wire logic       rst_n,
    // user side
    input wire logic       rspValid,
    input wire logic       rspRefused,
    input wire logic       initDone,
    // nand pins
    input wire logic       chipEnable_n,
    input wire logic       cmdLatch,
    input wire logic       addrLatch,
    input wire logic       writeStrobe_n,
    input wire logic       read_strobe_n,
    input wire logic       writeProtect_n,
    input wire logic [7:0] ioOut,
    input wire logic       ioOe,
    input wire logic       readyBusy_n
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    // opcodes that a busy target would drop
    wire idOp = ioOut inside {OP_READ_ID, OP_PARAM_PAGE, OP_UNIQUE_ID, OP_GET_FEAT, OP_SET_FEAT};
    // strobe phases and the quiet gap after a protect change
    sequence s_low2; !writeStrobe_n [*2]; endsequence
    sequence s_quiet; !cmdLatch [*8] ##1 !cmdLatch [*4]; endsequence
    property p_cmd; cmdLatch |-> !addrLatch && read_strobe_n && !chipEnable_n; endproperty
    property p_addr; addrLatch |-> !cmdLatch && read_strobe_n && !chipEnable_n; endproperty
    property p_strobe; $fell(writeStrobe_n) |=> s_low2 ##1 writeStrobe_n; endproperty
    property p_drive; !writeStrobe_n |-> ioOe; endproperty
    property p_wp_idle; $changed(writeProtect_n) |-> readyBusy_n && !cmdLatch && !addrLatch;
    endproperty
    property p_wp_wait; $changed(writeProtect_n) |=> s_quiet; endproperty
    property p_wp_init; !initDone |-> !writeProtect_n; endproperty
    property p_first; !initDone && $rose(cmdLatch) |-> ioOut == OP_RESET && readyBusy_n;
    endproperty
    property p_busy_id; $rose(cmdLatch) && idOp && initDone |-> readyBusy_n; endproperty
    property p_init; $rose(initDone) |-> readyBusy_n && $past(readyBusy_n); endproperty
    property p_refuse; rspRefused |-> !rspValid && !$past(readyBusy_n); endproperty
    a_cmd: assert property (p_cmd) else $error("command latch qualifiers wrong");
    a_addr: assert property (p_addr) else $error("address latch qualifiers wrong");
    a_strobe: assert property (p_strobe) else $error("write strobe low length wrong");
    a_drive: assert property (p_drive) else $error("bus not driven in write cycle");
    a_wp_idle: assert property (p_wp_idle) else $error("protect moved while busy");
    a_wp_wait: assert property (p_wp_wait) else $error("command too soon after protect");
    a_wp_init: assert property (p_wp_init) else $error("protect released before init");
    a_first: assert property (p_first) else $error("first command not reset");
    a_busy_id: assert property (p_busy_id) else $error("id or feature sent while busy");
    a_init: assert property (p_init) else $error("init done while target busy");
    a_refuse: assert property (p_refuse) else $error("request refused while ready");
endmodule
bind nand_target_control_init nand_target_control_init_checker #(
    .POWER_WAIT(POWER_WAIT), .RESET_BUSY(RESET_BUSY)) i_chk (
    .ref_clk(ref_clk), .rst_n(rst_n), .rspValid(rspValid), .rspRefused(rspRefused),
    .initDone(initDone), .chipEnable_n(chipEnable_n), .cmdLatch(cmdLatch),
    .addrLatch(addrLatch), .writeStrobe_n(writeStrobe_n), .read_strobe_n(read_strobe_n),
    .writeProtect_n(writeProtect_n), .ioOut(ioOut), .ioOe(ioOe), .readyBusy_n(readyBusy_n));
`default_nettype wire

// file: tb/nand_die_model.sv
// behavioural two-die nand target on the asynchronous strobe bus
// assumes strobes come from the host controller; pull-up modelled here
`timescale 1ns/1ps
`default_nettype none
module nand_die_model
    import nand_host_pkg::*;
#(
    parameter logic [7:0] ID_VAL   = 8'h00_5C, // arbitrary identifier value
    parameter int         RAMP_CYC = 30,
    parameter int         RST_CYC  = 60
) (
    // clocking and bench control
    input  wire logic       ref_clk,
    input  wire logic       holdBusy,
    // nand pins
    input  wire logic       chipEnable_n,
    input  wire logic       cmdLatch,
    input  wire logic       addrLatch,
    input  wire logic       writeStrobe_n,
    input  wire logic       read_strobe_n,
    input  wire logic       writeProtect_n,
    input  wire logic [7:0] ioOut,
    input  wire logic       ioOe,
    output logic [7:0]      ioIn,
    output logic            readyBusy_n,
    // observation
    output logic [7:0]      lastCmd,
    output logic [7:0]      cmdCount,
    output logic [7:0]      addrCount,
    output logic [7:0]      dataCount
);
    int         rampCnt = 0;
    time        rstAt   = 0;
    logic       rstBusy = 1'b1;
    logic       dieSel  = 1'b0;
    logic [1:0] dieRdy;
    logic [7:0] addr0, feat0, outByte;
    initial begin
        cmdCount = 0;
        addrCount = 0;
        dataCount = 0;
        lastCmd = 0;
    end
    // ramp and reset busy timing, both dies share the reset
    always @(posedge ref_clk) begin
        rampCnt <= rampCnt + 1;
        rstBusy <= $time < rstAt + RST_CYC * CLK_PERIOD_NS;
    end
    assign dieRdy = {~holdBusy & ~rstBusy, ~rstBusy};
    // open drain: low while any die busy, invalid low before ramp ends
    assign readyBusy_n = (rampCnt >= RAMP_CYC) & (&dieRdy);
    // only the asynchronous bus exists, latched on rising write strobe
    always @(posedge writeStrobe_n) if (!chipEnable_n && read_strobe_n) begin
        if (cmdLatch && !addrLatch) begin
            lastCmd <= ioOut;
            cmdCount <= cmdCount + 1;
            addrCount <= 0;
            dataCount <= 0;
            if (ioOut == OP_RESET) rstAt <= $time;
        end else if (addrLatch && !cmdLatch) begin
            addrCount <= addrCount + 1;
            if (addrCount == 0) addr0 <= ioOut;
            dieSel <= ioOut[0];
        end else if (!addrLatch) begin
            dataCount <= dataCount + 1;
            if (dataCount == 0 && lastCmd == OP_SET_FEAT) feat0 <= ioOut;
        end
    end
    // output byte; status shows the protect level in bit 7 and ready in bit 6
    always_comb case (lastCmd)
        OP_STATUS:     outByte = {writeProtect_n, &dieRdy, 6'h00};
        OP_STATUS_ENH: outByte = {writeProtect_n, dieRdy[dieSel], 6'h00};
        OP_GET_FEAT:   outByte = feat0;
        default:       outByte = ID_VAL ^ addr0;
    endcase
    // released bus shows the inverse so a stale byte cannot pass
    assign ioIn = ioOe ? ioOut : (read_strobe_n ? ~outByte : outByte);
endmodule
`default_nettype wire

// file: tb/test_nand_target_control_init.sv
// self-checking bench for the host nand controller against a die model
// assumes the package constants and a 125 MHz reference clock
`timescale 1ns/1ps
`default_nettype none
`define CHECK(a, b) begin check_count++; if ((a) !== (b)) begin failures++; \
    $display("wrong value at %0t: %h not %h", $time, a, b); end end
module test_nand_target_control_init;
    import nand_host_pkg::*;
    localparam logic [7:0] ID_VAL = 8'h00_5C; // arbitrary identifier value
    logic ref_clk = 0, rst_n = 0, clkEn = 1, reqValid = 0, reqProtect_n = 0;
    logic monitorRb = 0, holdBusy = 0, wpLvl = 0, rf, wp;
    logic [7:0] reqOpcode = 0, got, op, rspData, ioOut, ioIn, lastCmd, cmdCount;
    logic [7:0] addrCount, dataCount, nCmd;
    logic [23:0] reqAddr = 0, a;
    logic [31:0] reqData = 0, d;
    logic reqReady, rspValid, rspRefused, initDone, chipEnable_n, cmdLatch, addrLatch;
    logic writeStrobe_n, read_strobe_n, writeProtect_n, ioOe, readyBusy_n;
    logic [7:0] ops [7] = '{OP_STATUS, OP_STATUS_ENH, OP_READ_ID, OP_PARAM_PAGE,
                           OP_UNIQUE_ID, OP_SET_FEAT, OP_GET_FEAT};
    logic [7:0] featQ [$];
    int failures = 0, check_count = 0, i, n;
    nand_target_control_init #(.POWER_WAIT(20), .RESET_BUSY(40)) i_dut (
        .ref_clk(ref_clk), .rst_n(rst_n), .clkEn(clkEn), .reqValid(reqValid),
        .reqOpcode(reqOpcode), .reqAddr(reqAddr), .reqData(reqData),
        .reqProtect_n(reqProtect_n), .monitorRb(monitorRb), .reqReady(reqReady),
        .rspValid(rspValid), .rspData(rspData), .rspRefused(rspRefused),
        .initDone(initDone), .chipEnable_n(chipEnable_n), .cmdLatch(cmdLatch),
        .addrLatch(addrLatch), .writeStrobe_n(writeStrobe_n), .read_strobe_n(read_strobe_n),
        .writeProtect_n(writeProtect_n), .ioOut(ioOut), .ioOe(ioOe), .ioIn(ioIn),
        .readyBusy_n(readyBusy_n));
    nand_die_model #(.ID_VAL(ID_VAL)) i_model (
        .ref_clk(ref_clk), .holdBusy(holdBusy), .chipEnable_n(chipEnable_n),
        .cmdLatch(cmdLatch), .addrLatch(addrLatch), .writeStrobe_n(writeStrobe_n),
        .read_strobe_n(read_strobe_n), .writeProtect_n(writeProtect_n), .ioOut(ioOut),
        .ioOe(ioOe), .ioIn(ioIn), .readyBusy_n(readyBusy_n), .lastCmd(lastCmd),
        .cmdCount(cmdCount), .addrCount(addrCount), .dataCount(dataCount));
    // clock
    initial forever #4 ref_clk = ~ref_clk;
    // expected answer from the bench's own view of the target
    function automatic logic [7:0] expect_rsp(logic [7:0] o, logic [23:0] ad);
        case (o)
            OP_STATUS:     return {wpLvl, ~holdBusy, 6'h00};
            OP_STATUS_ENH: return {wpLvl, ~(holdBusy & ad[16]), 6'h00};
            OP_GET_FEAT:   return featQ[$];
            default:       return ID_VAL ^ ad[7:0];
        endcase
    endfunction
    // one request, held until answered or refused
    task automatic do_req(input logic [7:0] o, input logic [23:0] ad, input logic [31:0] dd);
        @(posedge ref_clk);
        #1;
        reqValid <= 1;
        reqOpcode <= o;
        reqAddr <= ad;
        reqData <= dd;
        reqProtect_n <= wpLvl;
        for (n = 0; n < 3000 && rspValid !== 1'b1 && rspRefused !== 1'b1; n++) begin
            @(posedge ref_clk);
            #1;
        end
        if (n == 3000) failures++;
        got = rspData;
        rf = rspRefused;
        reqValid <= 0;
    endtask
    task automatic wait_init();
        for (n = 0; n < 3000 && initDone !== 1'b1; n++) @(posedge ref_clk);
        if (n == 3000) failures++;
        #1;
    endtask
    task automatic complete_run();
        $display("comparisons %0d, mismatches %0d", check_count, failures);
        if (failures == 0 && check_count > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    // watchdog: the whole run needs well under this span
    initial begin
        #(CLK_PERIOD_NS * 40000);
        failures++;
        complete_run();
    end
    initial begin
        void'($urandom(63));
        repeat (10) @(posedge ref_clk);
        rst_n <= 1;
        wait_init();
        `CHECK({initDone, reqReady}, 2'b11)
        `CHECK({lastCmd, cmdCount}, {OP_RESET, 8'h01})
        // every opcode except reset, random fields and protect level
        for (i = 0; i < 21; i++) begin
            op = ops[i % 7];
            a = 24'($urandom());
            d = $urandom();
            wpLvl = 1'($urandom());
            if (op == OP_SET_FEAT) featQ.push_back(d[7:0]);
            do_req(op, a, d);
            `CHECK(rf, 1'b0)
            if (op != OP_SET_FEAT) `CHECK(got, expect_rsp(op, a))
            `CHECK(addrCount, op == OP_STATUS ? 8'h00 : op == OP_STATUS_ENH ? 8'h03 : 8'h01)
            `CHECK(dataCount, op == OP_SET_FEAT ? 8'h04 : 8'h00)
        end
        // one die held busy: id and feature refused, status still answered
        @(posedge ref_clk);
        holdBusy <= 1;
        nCmd = cmdCount;
        for (i = 2; i < 7; i++) begin
            do_req(ops[i], 24'h00_0000, 32'h0000_0000);
            `CHECK({rf, cmdCount}, {1'b1, nCmd})
        end
        for (i = 0; i < 4; i++) begin
            a = {7'h00, i[0], 16'h0000};
            do_req(ops[i[1]], a, 32'h0000_0000);
            `CHECK(got, expect_rsp(ops[i[1]], a))
        end
        @(posedge ref_clk);
        holdBusy <= 0;
        nCmd = cmdCount;
        // second reset, host now watching ready/busy
        rst_n <= 0;
        monitorRb <= 1;
        repeat (10) @(posedge ref_clk);
        rst_n <= 1;
        wait_init();
        `CHECK({initDone, lastCmd, cmdCount}, {1'b1, OP_RESET, nCmd + 8'h01})
        complete_run();
    end
endmodule
`default_nettype wire
